// ---- core/tc_defs.vh ----
`ifndef TC_DEFS_VH
`define TC_DEFS_VH

// Special function register addresses
`define TC_ADDR_CTRL01      8'h88
`define TC_ADDR_MODE01      8'h89
`define TC_ADDR_T0_LOW      8'h8A
`define TC_ADDR_T1_LOW      8'h8B
`define TC_ADDR_T0_HIGH     8'h8C
`define TC_ADDR_T1_HIGH     8'h8D
`define TC_ADDR_T2_CTRL     8'hC8
`define TC_ADDR_T2_RLD_LOW  8'hCA
`define TC_ADDR_T2_RLD_HIGH 8'hCB
`define TC_ADDR_T2_LOW      8'hCC
`define TC_ADDR_T2_HIGH     8'hCD

// Reset values
`define TC_RST_BYTE         8'h00

// Timer 0/1 control register bits
`define TC_CTRL_TF1         7
`define TC_CTRL_TR1         6
`define TC_CTRL_TF0         5
`define TC_CTRL_TR0         4

// Timer 0/1 mode register: one nibble per timer {gate, ct, mode[1:0]}
`define TC_MODE_T1_LSB      4
`define TC_MODE_T0_LSB      0
`define TC_NIB_GATE         3
`define TC_NIB_CT           2

// Timer 0/1 operating modes
`define TC_M_13BIT          2'h0
`define TC_M_16BIT          2'h1
`define TC_M_AUTO8          2'h2
`define TC_M_SPLIT          2'h3

// Timer 2 control register bits
`define TC_T2_TF2           7
`define TC_T2_TIMER2_EXTERNAL_FLAG          6
`define TC_T2_RCLK          5
`define TC_T2_TRANSMIT_CLOCK_SELECT          4
`define TC_T2_TIMER2_TRIGGER_ENABLE         3
`define TC_T2_TR2           2
`define TC_T2_TIMER2_COUNTER_SELECT          1
`define TC_T2_TIMER2_CAPTURE_SELECT          0

// Prescaler and machine cycle
`define TC_PRESCALE_BITS    5
`define TC_MC_DIV           4'hC
`define TC_MC_DIV_LAST      4'hB

`endif

// ---- core/tc_sync_edge.v ----
`timescale 1ns/1ps
`default_nettype none

module tc_sync_edge #(
   parameter W = 6
) (
   input  wire         clk_in,
   input  wire         sys_rst_in,
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] level_out,
   output reg  [W-1:0] fall_out
);

   reg [W-1:0] stage1;
   reg [W-1:0] prev;

   // First stage feeds only the second; edges come from later stages
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         stage1    <= {W{1'b1}};
         level_out <= {W{1'b1}};
         prev      <= {W{1'b1}};
         fall_out  <= {W{1'b0}};
      end else begin
         stage1    <= pin_in;
         level_out <= stage1;
         prev      <= level_out;
         fall_out  <= prev & ~level_out;
      end
   end

endmodule

`default_nettype wire

// ---- core/tc_timers.v ----
// Overview of operation
// - 13-bit mode: 8-bit counter behind divide-by-32
// - 13-bit count: high byte plus low five bits
// - Wrap to zero sets that timer's overflow flag
// - Count needs run bit and gate low or pin
// - Setting run bit never clears the counts
// - 16-bit mode uses both full bytes
// - Autoreload: low byte reloads from high byte
// - Timer 1 split mode holds its count
// - Split timer 0 low byte uses timer 0 controls
// - Split high byte: machine cycles, timer 1 run bit only, no gate
// - Timer 1 still feeds baud ticks, no flag
// - Timer 2 overflow flag, not in baud mode
// - External flag set on every enabled trigger edge, baud mode too
// - Receive clock select picks timer 2 or 1
// - Transmit clock select picks timer 2 or 1
// - Trigger edges act only when enabled; in baud mode they only set the flag
// - Timer 2 runs only while run bit set
// - Timer 2 counts pin edges or core clock
// - Capture select chooses capture or autoreload
// - Baud mode forces autoreload, capture ignored
// - Vectoring clears timer 0/1 overflow flags
// - Timer 2 reload loads from reload pair
// - Capture copies count bytes into reload pair
`timescale 1ns/1ps
`default_nettype none
`include "tc_defs.vh"

module tc_timers (
   input  wire       clk_in,
   input  wire       sys_rst_in,
   input  wire [7:0] sfr_addr_in,
   input  wire       sfr_wr_in,
   input  wire [7:0] sfr_wdata_in,
   input  wire       sfr_rd_in,
   output reg  [7:0] sfr_rdata_out,
   input  wire       timer0_count_pin_in,
   input  wire       timer1_count_pin_in,
   input  wire       external_interrupt_pin_zero_in,
   input  wire       external_interrupt_pin_one_in,
   input  wire       timer2_count_input_pin_in,
   input  wire       timer2_trigger_pin_in,
   input  wire       timer0_vector_ack_in,
   input  wire       timer1_vector_ack_in,
   output reg        timer0_overflow_flag_out,
   output reg        timer1_overflow_flag_out,
   output reg        timer2_overflow_flag_out,
   output reg        timer2_external_flag_out,
   output reg        rx_baud_tick_out,
   output reg        tx_baud_tick_out
);

   reg  [7:0]  timer0_count_low, timer0_count_high, timer1_count_low, timer1_count_high;
   reg  [7:0]  timer01_mode_reg, timer2_count_low, timer2_count_high;
   reg  [7:0]  timer2_reload_low, timer2_reload_high;
   reg         timer0_run_bit, timer1_run_bit, transmit_clock_select, receive_clock_select;
   reg         timer2_trigger_enable, timer2_run_bit, timer2_counter_select;
   reg         timer2_capture_select, mc_tick;
   reg  [3:0]  mc_count;

   wire [5:0]  pin_level, pin_fall;
   wire [16:0] step0, step1;
   wire [3:0]  t0_nib, t1_nib;
   wire [1:0]  t0_mode, t1_mode;
   wire        t0_split, t0_tick, t1_tick, t0_adv, t1_adv, th0_adv, th0_ovf, t0_ovf, t1_ovf;
   wire        baud_mode, t2_tick, t2_adv, t2_ovf, t2_trig, t2_capture, t2_reload;
   wire [15:0] t2_inc;
   wire        wr_ctrl01, wr_mode01, wr_t0l, wr_t0h, wr_t1l, wr_t1h;
   wire        wr_t2ctl, wr_t2rl, wr_t2rh, wr_t2l, wr_t2h;

   reg  [7:0]  next_rdata, next_t0_high, next_t2_low, next_t2_high;
   reg  [7:0]  next_rld_low, next_rld_high;

   function wr_at;
      input [7:0] addr;
      begin
         wr_at = sfr_wr_in && (sfr_addr_in == addr);
      end
   endfunction

   // One count step for timers 0/1: returns {overflow, high, low}
   function [16:0] tc_step;
      input [1:0] mode;
      input [7:0] hi;
      input [7:0] lo;
      reg   [5:0] lo5;
      reg   [8:0] hi9;
      reg   [16:0] full;
      begin
         lo5  = {1'b0, lo[4:0]} + 6'h01;
         hi9  = {1'b0, hi} + {8'h00, lo5[5]};
         full = {1'b0, hi, lo} + 17'h00001;
         case (mode)
            `TC_M_13BIT: begin
               // Upper three low-byte bits are left alone, software ignores them
               tc_step = {hi9[8], hi9[7:0], lo[7:5], lo5[4:0]};
            end
            `TC_M_16BIT: tc_step = full;
            `TC_M_AUTO8: begin
               if (lo == 8'hFF) begin
                  tc_step = {1'b1, hi, hi};
               end else begin
                  tc_step = {1'b0, hi, lo + 8'h01};
               end
            end
            default: tc_step = {(lo == 8'hFF), hi, lo + 8'h01};
         endcase
      end
   endfunction

   tc_sync_edge #(
      .W (6)
   ) u_pins (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .pin_in     ({timer2_trigger_pin_in, timer2_count_input_pin_in,
                    external_interrupt_pin_one_in, external_interrupt_pin_zero_in,
                    timer1_count_pin_in, timer0_count_pin_in}),
      .level_out  (pin_level),
      .fall_out   (pin_fall)
   );

   assign wr_ctrl01 = wr_at(`TC_ADDR_CTRL01);
   assign wr_mode01 = wr_at(`TC_ADDR_MODE01);
   assign wr_t0l    = wr_at(`TC_ADDR_T0_LOW);
   assign wr_t0h    = wr_at(`TC_ADDR_T0_HIGH);
   assign wr_t1l    = wr_at(`TC_ADDR_T1_LOW);
   assign wr_t1h    = wr_at(`TC_ADDR_T1_HIGH);
   assign wr_t2ctl  = wr_at(`TC_ADDR_T2_CTRL);
   assign wr_t2rl   = wr_at(`TC_ADDR_T2_RLD_LOW);
   assign wr_t2rh   = wr_at(`TC_ADDR_T2_RLD_HIGH);
   assign wr_t2l    = wr_at(`TC_ADDR_T2_LOW);
   assign wr_t2h    = wr_at(`TC_ADDR_T2_HIGH);

   // Machine cycle divider
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         mc_count <= 4'h0;
         mc_tick  <= 1'b0;
      end else begin
         mc_tick  <= (mc_count == `TC_MC_DIV_LAST);
         mc_count <= (mc_count == `TC_MC_DIV_LAST) ? 4'h0 : mc_count + 4'h1;
      end
   end

   assign t0_nib   = timer01_mode_reg[`TC_MODE_T0_LSB +: 4];
   assign t1_nib   = timer01_mode_reg[`TC_MODE_T1_LSB +: 4];
   assign t0_mode  = t0_nib[1:0];
   assign t1_mode  = t1_nib[1:0];
   assign t0_split = (t0_mode == `TC_M_SPLIT);

   assign t0_tick = t0_nib[`TC_NIB_CT] ? pin_fall[0] : mc_tick;
   assign t1_tick = t1_nib[`TC_NIB_CT] ? pin_fall[1] : mc_tick;

   // Split low byte keeps all of timer 0's own controls
   assign t0_adv = t0_tick && timer0_run_bit &&
                   (!t0_nib[`TC_NIB_GATE] || pin_level[2]);
   // Timer 1 split mode acts as a cleared run bit
   assign t1_adv = t1_tick && timer1_run_bit && (t1_mode != `TC_M_SPLIT) &&
                   (!t1_nib[`TC_NIB_GATE] || pin_level[3]);
   // Borrowed high byte: machine cycles, timer 1 run bit, no gate
   assign th0_adv = t0_split && mc_tick && timer1_run_bit;
   assign th0_ovf = th0_adv && (timer0_count_high == 8'hFF);

   assign step0  = tc_step(t0_mode, timer0_count_high, timer0_count_low);
   assign step1  = tc_step(t1_mode, timer1_count_high, timer1_count_low);
   assign t0_ovf = t0_adv && step0[16];
   assign t1_ovf = t1_adv && step1[16];

   always @* begin
      next_t0_high = timer0_count_high;
      if (wr_t0h) begin
         next_t0_high = sfr_wdata_in;
      end else if (t0_split) begin
         if (th0_adv) begin
            next_t0_high = timer0_count_high + 8'h01;
         end
      end else if (t0_adv) begin
         next_t0_high = step0[15:8];
      end
   end

   // Software writes win over a count step in the same cycle
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         timer0_count_low  <= `TC_RST_BYTE;
         timer0_count_high <= `TC_RST_BYTE;
         timer1_count_low  <= `TC_RST_BYTE;
         timer1_count_high <= `TC_RST_BYTE;
         timer01_mode_reg  <= `TC_RST_BYTE;
         timer0_run_bit    <= 1'b0;
         timer1_run_bit    <= 1'b0;
      end else begin
         timer0_count_high <= next_t0_high;
         if (wr_t0l) begin
            timer0_count_low <= sfr_wdata_in;
         end else if (t0_adv) begin
            timer0_count_low <= step0[7:0];
         end
         if (wr_t1l) begin
            timer1_count_low <= sfr_wdata_in;
         end else if (t1_adv) begin
            timer1_count_low <= step1[7:0];
         end
         if (wr_t1h) begin
            timer1_count_high <= sfr_wdata_in;
         end else if (t1_adv) begin
            timer1_count_high <= step1[15:8];
         end
         if (wr_mode01) begin
            timer01_mode_reg <= sfr_wdata_in;
         end
         // Run bits only gate counting, counts stay as they are
         if (wr_ctrl01) begin
            timer0_run_bit <= sfr_wdata_in[`TC_CTRL_TR0];
            timer1_run_bit <= sfr_wdata_in[`TC_CTRL_TR1];
         end
      end
   end

   // Overflow flags: a set in the clearing cycle still lands
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         timer0_overflow_flag_out <= 1'b0;
         timer1_overflow_flag_out <= 1'b0;
      end else begin
         if (t0_ovf) begin
            timer0_overflow_flag_out <= 1'b1;
         end else if (wr_ctrl01) begin
            timer0_overflow_flag_out <= sfr_wdata_in[`TC_CTRL_TF0];
         end else if (timer0_vector_ack_in) begin
            timer0_overflow_flag_out <= 1'b0;
         end
         // While timer 0 is split, the flag belongs to its high byte
         if (t0_split ? th0_ovf : t1_ovf) begin
            timer1_overflow_flag_out <= 1'b1;
         end else if (wr_ctrl01) begin
            timer1_overflow_flag_out <= sfr_wdata_in[`TC_CTRL_TF1];
         end else if (timer1_vector_ack_in) begin
            timer1_overflow_flag_out <= 1'b0;
         end
      end
   end

   assign baud_mode = receive_clock_select || transmit_clock_select;
   assign t2_tick   = timer2_counter_select ? pin_fall[4] : 1'b1;
   assign t2_adv    = timer2_run_bit && t2_tick;
   assign t2_inc    = {timer2_count_high, timer2_count_low} + 16'h0001;
   assign t2_ovf    = t2_adv && ({timer2_count_high, timer2_count_low} == 16'hFFFF);
   assign t2_trig   = pin_fall[5] && timer2_trigger_enable;
   // Baud mode takes trigger edges away from capture and reload
   assign t2_capture = t2_trig && !baud_mode && timer2_capture_select;
   assign t2_reload  = (t2_ovf && (baud_mode || !timer2_capture_select)) ||
                       (t2_trig && !baud_mode && !timer2_capture_select);

   always @* begin
      next_t2_low   = timer2_count_low;
      next_t2_high  = timer2_count_high;
      next_rld_low  = timer2_reload_low;
      next_rld_high = timer2_reload_high;
      if (t2_reload) begin
         next_t2_low  = timer2_reload_low;
         next_t2_high = timer2_reload_high;
      end else if (t2_adv) begin
         next_t2_low  = t2_inc[7:0];
         next_t2_high = t2_inc[15:8];
      end
      if (t2_capture) begin
         next_rld_low  = timer2_count_low;
         next_rld_high = timer2_count_high;
      end
      if (wr_t2l) next_t2_low = sfr_wdata_in;
      if (wr_t2h) next_t2_high = sfr_wdata_in;
      if (wr_t2rl) next_rld_low = sfr_wdata_in;
      if (wr_t2rh) next_rld_high = sfr_wdata_in;
   end

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         timer2_count_low         <= `TC_RST_BYTE;
         timer2_count_high        <= `TC_RST_BYTE;
         timer2_reload_low        <= `TC_RST_BYTE;
         timer2_reload_high       <= `TC_RST_BYTE;
         receive_clock_select     <= 1'b0;
         transmit_clock_select    <= 1'b0;
         timer2_trigger_enable    <= 1'b0;
         timer2_run_bit           <= 1'b0;
         timer2_counter_select    <= 1'b0;
         timer2_capture_select    <= 1'b0;
         timer2_overflow_flag_out <= 1'b0;
         timer2_external_flag_out <= 1'b0;
      end else begin
         timer2_count_low   <= next_t2_low;
         timer2_count_high  <= next_t2_high;
         timer2_reload_low  <= next_rld_low;
         timer2_reload_high <= next_rld_high;
         if (wr_t2ctl) begin
            receive_clock_select  <= sfr_wdata_in[`TC_T2_RCLK];
            transmit_clock_select <= sfr_wdata_in[`TC_T2_TRANSMIT_CLOCK_SELECT];
            timer2_trigger_enable <= sfr_wdata_in[`TC_T2_TIMER2_TRIGGER_ENABLE];
            timer2_run_bit        <= sfr_wdata_in[`TC_T2_TR2];
            timer2_counter_select <= sfr_wdata_in[`TC_T2_TIMER2_COUNTER_SELECT];
            timer2_capture_select <= sfr_wdata_in[`TC_T2_TIMER2_CAPTURE_SELECT];
         end
         // Only software clears these; hardware set wins a tie
         if (t2_ovf && !baud_mode) begin
            timer2_overflow_flag_out <= 1'b1;
         end else if (wr_t2ctl) begin
            timer2_overflow_flag_out <= sfr_wdata_in[`TC_T2_TF2];
         end
         // Edge still flags in baud mode so it can serve as an extra interrupt
         if (t2_trig) begin
            timer2_external_flag_out <= 1'b1;
         end else if (wr_t2ctl) begin
            timer2_external_flag_out <= sfr_wdata_in[`TC_T2_TIMER2_EXTERNAL_FLAG];
         end
      end
   end

   // Timer 1 ticks keep flowing to the serial port even while timer 0 is split
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         rx_baud_tick_out <= 1'b0;
         tx_baud_tick_out <= 1'b0;
      end else begin
         rx_baud_tick_out <= receive_clock_select ? t2_ovf : t1_ovf;
         tx_baud_tick_out <= transmit_clock_select ? t2_ovf : t1_ovf;
      end
   end

   always @* begin
      case (sfr_addr_in)
         `TC_ADDR_CTRL01: begin
            next_rdata = {timer1_overflow_flag_out, timer1_run_bit,
                          timer0_overflow_flag_out, timer0_run_bit, 4'h0};
         end
         `TC_ADDR_MODE01:      next_rdata = timer01_mode_reg;
         `TC_ADDR_T0_LOW:      next_rdata = timer0_count_low;
         `TC_ADDR_T0_HIGH:     next_rdata = timer0_count_high;
         `TC_ADDR_T1_LOW:      next_rdata = timer1_count_low;
         `TC_ADDR_T1_HIGH:     next_rdata = timer1_count_high;
         `TC_ADDR_T2_CTRL: begin
            next_rdata = {timer2_overflow_flag_out, timer2_external_flag_out,
                          receive_clock_select, transmit_clock_select,
                          timer2_trigger_enable, timer2_run_bit,
                          timer2_counter_select, timer2_capture_select};
         end
         `TC_ADDR_T2_RLD_LOW:  next_rdata = timer2_reload_low;
         `TC_ADDR_T2_RLD_HIGH: next_rdata = timer2_reload_high;
         `TC_ADDR_T2_LOW:      next_rdata = timer2_count_low;
         `TC_ADDR_T2_HIGH:     next_rdata = timer2_count_high;
         default:              next_rdata = 8'h00;
      endcase
   end

   // Read data held until the next read
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_rd_in) begin
         sfr_rdata_out <= next_rdata;
      end
   end

endmodule

`default_nettype wire

// ---- test/tc_timers_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module tc_timers_properties (
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic [7:0] sfr_addr_in,
   input  wire logic       sfr_wr_in,
   input  wire logic [7:0] sfr_wdata_in,
   input  wire logic       sfr_rd_in,
   input  wire logic [7:0] sfr_rdata_out,
   input  wire logic       timer0_overflow_flag_out,
   input  wire logic       timer1_overflow_flag_out,
   input  wire logic       timer2_overflow_flag_out,
   input  wire logic       timer2_external_flag_out,
   input  wire logic       rx_baud_tick_out,
   input  wire logic       tx_baud_tick_out
);
   // Shadows of software-only control bits; flag bits in them are ignored
   logic [7:0] c01;
   logic [7:0] m01;
   logic [7:0] c2;
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         c01 <= 8'h00;
         m01 <= 8'h00;
         c2  <= 8'h00;
      end else if (sfr_wr_in) begin
         if (sfr_addr_in == 8'h88) c01 <= sfr_wdata_in;
         if (sfr_addr_in == 8'h89) m01 <= sfr_wdata_in;
         if (sfr_addr_in == 8'hC8) c2 <= sfr_wdata_in;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   rd_unmapped_a: assert property (sfr_rd_in && sfr_addr_in == 8'hFF |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
      else $error("read data moved without a read");
   tf0_run_a: assert property ($rose(timer0_overflow_flag_out) |-> $past(c01[4]) || $past(sfr_wr_in))
      else $error("timer 0 flag set while stopped");
   tf1_run_a: assert property ($rose(timer1_overflow_flag_out) |-> $past(c01[6]) || $past(sfr_wr_in))
      else $error("timer 1 flag set while stopped");
   tf2_run_a: assert property ($rose(timer2_overflow_flag_out) |-> $past(c2[2]) || $past(sfr_wr_in))
      else $error("timer 2 flag set while stopped");
   tf2_baud_a: assert property ((c2[5] || c2[4]) && !sfr_wr_in |=> !$rose(timer2_overflow_flag_out))
      else $error("timer 2 flag set in baud mode");
   timer2_external_flag_enable_a: assert property (!c2[3] && !sfr_wr_in |=> !$rose(timer2_external_flag_out))
      else $error("external flag set while trigger disabled");
   rx_t2_quiet_a: assert property ((c2[5] && !c2[2])[*3] |-> !rx_baud_tick_out)
      else $error("receive tick from stopped timer 2");
   rx_t1_quiet_a: assert property ((!c2[5] && !c01[6] && m01[1:0] != 2'h3)[*3] |-> !rx_baud_tick_out)
      else $error("receive tick from stopped timer 1");
   tx_t1_quiet_a: assert property ((!c2[4] && !c01[6] && m01[1:0] != 2'h3)[*3] |-> !tx_baud_tick_out)
      else $error("transmit tick from stopped timer 1");
   cover property ($rose(timer0_overflow_flag_out));
   cover property ($rose(timer2_overflow_flag_out));
   cover property ($rose(timer2_external_flag_out));
   cover property (rx_baud_tick_out && c2[5]);
endmodule
bind tc_timers tc_timers_properties u_props (
   .clk_in, .sys_rst_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rd_in, .sfr_rdata_out,
   .timer0_overflow_flag_out, .timer1_overflow_flag_out, .timer2_overflow_flag_out,
   .timer2_external_flag_out, .rx_baud_tick_out, .tx_baud_tick_out
);
`default_nettype wire

// ---- test/tc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tc_core_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] sfr_rdata_in,
   output var  logic [7:0] sfr_addr_out,
   output var  logic       sfr_wr_out,
   output var  logic [7:0] sfr_wdata_out,
   output var  logic       sfr_rd_out,
   output var  logic       vec0_out,
   output var  logic       vec1_out
);
   initial begin
      sfr_addr_out = 8'h00;
      sfr_wr_out = 1'b0;
      sfr_wdata_out = 8'h00;
      sfr_rd_out = 1'b0;
      vec0_out = 1'b0;
      vec1_out = 1'b0;
   end
   // Released bus shows the inverse so a stale value never passes
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      sfr_addr_out = a;
      sfr_wdata_out = d;
      sfr_wr_out = 1'b1;
      @(negedge clk_in);
      sfr_wr_out = 1'b0;
      sfr_addr_out = ~a;
      sfr_wdata_out = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_in);
      sfr_addr_out = a;
      sfr_rd_out = 1'b1;
      @(negedge clk_in);
      sfr_rd_out = 1'b0;
      sfr_addr_out = ~a;
      d = sfr_rdata_in;
   endtask
   task automatic ack(input int n);
      @(negedge clk_in);
      if (n == 0) vec0_out = 1'b1;
      else vec1_out = 1'b1;
      @(negedge clk_in);
      vec0_out = 1'b0;
      vec1_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- test/timer_counter_units_0_1_2_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer_counter_units_0_1_2_control_tb;
   logic       clk_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic [5:0] pins = 6'h3F;
   logic [7:0] addr, wdata, rdata;
   logic       wr, rd, ack0, ack1, rxt, txt;
   logic [3:0] flg;
   int         fails = 0;
   int         checks_done = 0;
   int         rx_n = 0;
   int         tx_n = 0;
   int         n, k, j;
   always #2 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      if (rxt === 1'b1) rx_n <= rx_n + 1;
      if (txt === 1'b1) tx_n <= tx_n + 1;
   end
   tc_core_model m (.clk_in(clk_in), .sfr_rdata_in(rdata), .sfr_addr_out(addr),
      .sfr_wr_out(wr), .sfr_wdata_out(wdata), .sfr_rd_out(rd), .vec0_out(ack0), .vec1_out(ack1));
   tc_timers dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
      .sfr_wdata_in(wdata), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
      .timer0_count_pin_in(pins[0]), .timer1_count_pin_in(pins[1]),
      .external_interrupt_pin_zero_in(pins[2]), .external_interrupt_pin_one_in(pins[3]),
      .timer2_count_input_pin_in(pins[4]), .timer2_trigger_pin_in(pins[5]),
      .timer0_vector_ack_in(ack0), .timer1_vector_ack_in(ack1),
      .timer0_overflow_flag_out(flg[0]), .timer1_overflow_flag_out(flg[1]),
      .timer2_overflow_flag_out(flg[2]), .timer2_external_flag_out(flg[3]),
      .rx_baud_tick_out(rxt), .tx_baud_tick_out(txt));
   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      m.rd(a, v);
      chk(v, exp);
   endtask
   // Bounded poll; a flag that never comes ends the run
   task automatic wait_flag(input int i, input int lim, output int cyc);
      cyc = 0;
      while (flg[i] !== 1'b1 && cyc < lim) begin
         @(negedge clk_in);
         cyc++;
      end
      if (cyc >= lim) begin
         fails++;
         complete_run();
      end
   endtask
   task automatic fall(input int i);
      @(negedge clk_in);
      pins[i] = 1'b0;
      repeat (4) @(negedge clk_in);
      pins[i] = 1'b1;
      repeat (4) @(negedge clk_in);
   endtask
   initial begin
      repeat (10) @(negedge clk_in);
      sys_rst_in = 1'b0;
      rchk(8'hC8, 8'h00);
      rchk(8'hFF, 8'h00);
      m.wr(8'h89, 8'h02);
      m.wr(8'h8C, 8'hF0);
      m.wr(8'h8A, 8'hFE);
      m.wr(8'h88, 8'h10);
      wait_flag(0, 60, n);
      m.wr(8'h88, 8'h00);
      rchk(8'h8A, 8'hF0);
      rchk(8'h8C, 8'hF0);
      pins[2] = 1'b0;
      m.wr(8'h89, 8'h0A);
      m.wr(8'h88, 8'h10);
      repeat (40) @(negedge clk_in);
      rchk(8'h8A, 8'hF0);
      m.ack(0);
      rchk(8'h88, 8'h10);
      pins[2] = 1'b1;
      wait_flag(0, 260, n);
      m.wr(8'h88, 8'h00);
      chk(8'(n > 180), 8'h01);
      m.ack(0);
      m.wr(8'h89, 8'h00);
      m.wr(8'h8C, 8'hFE);
      m.wr(8'h8A, 8'hFF);
      m.wr(8'h88, 8'h10);
      wait_flag(0, 450, n);
      m.wr(8'h88, 8'h00);
      chk(8'(n > 372), 8'h01);
      rchk(8'h8C, 8'h00);
      rchk(8'h8A, 8'hE0);
      m.wr(8'h89, 8'h50);
      m.wr(8'h8D, 8'hFF);
      m.wr(8'h8B, 8'hFE);
      m.wr(8'h88, 8'h40);
      k = rx_n;
      j = tx_n;
      fall(1);
      rchk(8'h8B, 8'hFF);
      fall(1);
      rchk(8'h88, 8'hC0);
      rchk(8'h8D, 8'h00);
      chk(8'(rx_n - k), 8'h01);
      chk(8'(tx_n - j), 8'h01);
      m.ack(1);
      rchk(8'h88, 8'h40);
      m.wr(8'h89, 8'h30);
      m.wr(8'h8B, 8'hAA);
      repeat (3) fall(1);
      rchk(8'h8B, 8'hAA);
      m.wr(8'h8C, 8'hFF);
      m.wr(8'h89, 8'h33);
      wait_flag(1, 40, n);
      m.wr(8'h8A, 8'hFF);
      m.wr(8'h88, 8'h50);
      wait_flag(0, 40, n);
      rchk(8'h88, 8'h70);
      m.wr(8'h8D, 8'hFF);
      m.wr(8'h8B, 8'hFF);
      k = rx_n;
      m.wr(8'h89, 8'h23);
      repeat (40) @(negedge clk_in);
      chk(8'(rx_n - k > 1), 8'h01);
      rchk(8'h88, 8'h70);
      m.wr(8'h88, 8'h00);
      m.wr(8'h89, 8'h00);
      m.wr(8'hCA, 8'h34);
      m.wr(8'hCB, 8'h12);
      m.wr(8'hCC, 8'hFE);
      m.wr(8'hCD, 8'hFF);
      m.wr(8'hC8, 8'h04);
      m.wr(8'hC8, 8'h00);
      rchk(8'hCC, 8'h34);
      rchk(8'hCD, 8'h12);
      rchk(8'hC8, 8'h80);
      m.wr(8'hC8, 8'h01);
      fall(5);
      rchk(8'hC8, 8'h01);
      m.wr(8'hCC, 8'h78);
      m.wr(8'hCD, 8'h56);
      m.wr(8'hC8, 8'h09);
      fall(5);
      rchk(8'hCA, 8'h78);
      rchk(8'hCB, 8'h56);
      rchk(8'hC8, 8'h49);
      m.wr(8'hC8, 8'h08);
      m.wr(8'hCC, 8'h00);
      fall(5);
      rchk(8'hCC, 8'h78);
      rchk(8'hC8, 8'h48);
      m.wr(8'hCC, 8'h00);
      m.wr(8'hCD, 8'h00);
      m.wr(8'hC8, 8'h06);
      repeat (3) fall(4);
      m.wr(8'hC8, 8'h00);
      rchk(8'hCC, 8'h03);
      m.wr(8'hCA, 8'hF0);
      m.wr(8'hCB, 8'hFF);
      m.wr(8'hCC, 8'hF0);
      m.wr(8'hCD, 8'hFF);
      k = rx_n;
      j = tx_n;
      m.wr(8'hC8, 8'h35);
      repeat (64) @(negedge clk_in);
      rchk(8'hCD, 8'hFF);
      rchk(8'hC8, 8'h35);
      chk(8'(rx_n - k > 2), 8'h01);
      chk(8'(tx_n - j > 2), 8'h01);
      complete_run();
   end
endmodule
`default_nettype wire
